// ==== src/tcc_pkg.sv ====
package tcc_pkg;
   localparam int NUM_CH       = 5;
   localparam int CTRL_W       = 8;
   localparam int CNT_W        = 16;
   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 32;
   localparam int NUM_EXT      = 4;
   localparam int PRESC_W      = 3;

   // Byte addresses: control of channel n at CTRL_BASE + 4n, counter at CNT_BASE + 4n
   localparam logic [ADDR_W-1:0] CTRL_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] CNT_BASE  = 8'h20;
   localparam logic [ADDR_W-1:0] REG_STEP  = 8'h04;

   // Field positions
   localparam int RSV_BIT      = 7;
   localparam int CLR_HI_BIT   = 6;
   localparam int CLR_LO_BIT   = 5;
   localparam int EDGE_HI_BIT  = 4;
   localparam int EDGE_LO_BIT  = 3;
   localparam int PRESC_HI_BIT = 2;
   localparam int PRESC_LO_BIT = 0;

   localparam logic [CTRL_W-1:0] CTRL_RESET    = 8'h00;
   localparam logic [CTRL_W-1:0] CTRL_WR_MASK  = 8'h7f;
   localparam logic [CNT_W-1:0]  CNT_RESET     = 16'h0000;
   localparam logic [PRESC_W-1:0] PRESC_RESET  = 3'h0;

   // Clear source codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_GRA  = 2'h1;
   localparam logic [1:0] CLR_GRB  = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;

   // Edge codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;

   localparam int PHASE_CH = 2;
endpackage

// ==== src/tcc_channel.sv ====
module tcc_channel (
   // Clock and reset
   input  wire logic                              sys_clk,
   input  wire logic                              rstSync_n,
   // Control
   input  wire logic [tcc_pkg::CTRL_W-1:0]        ctrl,
   input  wire logic                              phaseMode,
   input  wire logic                              phaseUp,
   input  wire logic                              phaseDown,
   // Count sources
   input  wire logic [tcc_pkg::NUM_EXT-1:0]       intTick,
   input  wire logic [tcc_pkg::NUM_EXT-1:0]       extRise,
   input  wire logic [tcc_pkg::NUM_EXT-1:0]       extFall,
   // Clear events
   input  wire logic                              eventA,
   input  wire logic                              eventB,
   input  wire logic                              syncClear,
   output logic                                   ownClear,
   // Counter
   output logic [tcc_pkg::CNT_W-1:0]              counter
);
   import tcc_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } tcc_ch_state_t;

   tcc_ch_state_t state;
   tcc_ch_state_t next_state;

   logic [1:0]   clrSel;
   logic [1:0]   edgeSel;
   logic [2:0]   presc;
   logic         extPick;
   logic         tick;
   logic         doClear;

   assign clrSel  = ctrl[CLR_HI_BIT:CLR_LO_BIT];
   assign edgeSel = ctrl[EDGE_HI_BIT:EDGE_LO_BIT];
   assign presc   = ctrl[PRESC_HI_BIT:PRESC_LO_BIT];

   always_comb begin
      ownClear = (clrSel == CLR_GRA && eventA) || (clrSel == CLR_GRB && eventB);
      doClear  = ownClear || (clrSel == CLR_SYNC && syncClear);
      extPick  = 1'b0;
      if (presc[2]) begin
         if (edgeSel[1])
            extPick = extRise[presc[1:0]] | extFall[presc[1:0]];
         else if (edgeSel == EDGE_FALL)
            extPick = extFall[presc[1:0]];
         else
            extPick = extRise[presc[1:0]];
      end
      // Prescaler code selects internal divided tick or an external edge
      tick = presc[2] ? extPick : intTick[presc[1:0]];
      next_state = state;
      if (doClear)
         next_state.count = CNT_RESET;
      else if (phaseMode) begin
         // Phase counting overrides edge and prescaler fields
         if (phaseUp && !phaseDown)
            next_state.count = state.count + 16'h0001;
         else if (phaseDown && !phaseUp)
            next_state.count = state.count - 16'h0001;
      end
      else if (tick)
         next_state.count = state.count + 16'h0001;
   end

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n)
         state <= '{count: CNT_RESET};
      else
         state <= next_state;
   end

   assign counter = state.count;
endmodule

// ==== src/tcc_timer_unit.sv ====
module tcc_timer_unit (
   // Clock and reset
   input  wire logic                              sys_clk,
   input  wire logic                              reset_n,
   // APB slave
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [tcc_pkg::ADDR_W-1:0]        paddr,
   input  wire logic [tcc_pkg::DATA_W-1:0]        pwdata,
   output logic [tcc_pkg::DATA_W-1:0]             prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   // Power state
   input  wire logic                              standby,
   // External clock pins (asynchronous)
   input  wire logic [tcc_pkg::NUM_EXT-1:0]       extClockPin,
   // General register events, one bit per channel
   input  wire logic [tcc_pkg::NUM_CH-1:0]        compareMatchA,
   input  wire logic [tcc_pkg::NUM_CH-1:0]        captureA,
   input  wire logic [tcc_pkg::NUM_CH-1:0]        regAIsCapture,
   input  wire logic [tcc_pkg::NUM_CH-1:0]        compareMatchB,
   input  wire logic [tcc_pkg::NUM_CH-1:0]        captureB,
   input  wire logic [tcc_pkg::NUM_CH-1:0]        regBIsCapture,
   // Synchronous operation group
   input  wire logic [tcc_pkg::NUM_CH-1:0]        syncMember,
   // Phase counting on channel 2
   input  wire logic                              phaseMode,
   input  wire logic                              phaseUp,
   input  wire logic                              phaseDown,
   // Counter values
   output logic [tcc_pkg::NUM_CH*tcc_pkg::CNT_W-1:0] channelCounter
);
   import tcc_pkg::*;

   typedef struct packed {
      logic [PRESC_W-1:0]             presc;
      logic [NUM_EXT-1:0]             extSync1;
      logic [NUM_EXT-1:0]             extSync2;
      logic [NUM_EXT-1:0]             extPrev;
      logic [NUM_CH-1:0][CTRL_W-1:0]  ctrl;
      logic                           ready;
      logic [DATA_W-1:0]              rdata;
      logic                           slvErr;
   } tcc_state_t;

   tcc_state_t state;
   tcc_state_t next_state;

   logic [1:0]                  rstPipe;
   logic                        rstSync_n;
   logic [NUM_EXT-1:0]          intTick;
   logic [NUM_EXT-1:0]          extRise;
   logic [NUM_EXT-1:0]          extFall;
   logic [NUM_CH-1:0]           eventA;
   logic [NUM_CH-1:0]           eventB;
   logic [NUM_CH-1:0]           ownClear;
   logic                        syncClear;
   logic [NUM_CH-1:0][CNT_W-1:0] cnt;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstSync_n = rstPipe[1];

   // Internal ticks: /1, /2, /4, /8 from a free-running prescaler
   always_comb begin
      intTick[0] = 1'b1;
      intTick[1] = state.presc[0];
      intTick[2] = &state.presc[1:0];
      intTick[3] = &state.presc[2:0];
   end

   // Edge detection reads only the second synchroniser stage
   assign extRise = state.extSync2 & ~state.extPrev;
   assign extFall = ~state.extSync2 & state.extPrev;

   // Register function picks compare match or capture as the event
   assign eventA = (regAIsCapture & captureA) | (~regAIsCapture & compareMatchA);
   assign eventB = (regBIsCapture & captureB) | (~regBIsCapture & compareMatchB);

   // Any in-group clear is seen by group members using code 11
   assign syncClear = |(ownClear & syncMember);

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         tcc_channel u_channel (
            .sys_clk   (sys_clk),
            .rstSync_n (rstSync_n),
            .ctrl      (state.ctrl[g]),
            .phaseMode ((g == PHASE_CH) ? phaseMode : 1'b0),
            .phaseUp   (phaseUp),
            .phaseDown (phaseDown),
            .intTick   (intTick),
            .extRise   (extRise),
            .extFall   (extFall),
            .eventA    (eventA[g]),
            .eventB    (eventB[g]),
            .syncClear (syncClear & syncMember[g]),
            .ownClear  (ownClear[g]),
            .counter   (cnt[g])
         );
         assign channelCounter[g*CNT_W +: CNT_W] = cnt[g];
      end
   endgenerate

   // APB access decode
   logic                access;
   logic [ADDR_W-1:0]   offs;
   logic                isCtrl;
   logic                isCnt;
   logic [2:0]          idx;

   always_comb begin
      access = psel && penable;
      isCtrl = 1'b0;
      isCnt  = 1'b0;
      idx    = 3'h0;
      offs   = 8'h00;
      if (paddr[1:0] == 2'h0) begin
         if (paddr >= CTRL_BASE && paddr < CTRL_BASE + 8'(NUM_CH) * REG_STEP) begin
            offs   = paddr - CTRL_BASE;
            idx    = offs[4:2];
            isCtrl = 1'b1;
         end
         else if (paddr >= CNT_BASE && paddr < CNT_BASE + 8'(NUM_CH) * REG_STEP) begin
            offs  = paddr - CNT_BASE;
            idx   = offs[4:2];
            isCnt = 1'b1;
         end
      end
   end

   always_comb begin
      next_state          = state;
      next_state.presc    = state.presc + 3'h1;
      next_state.extSync1 = extClockPin;
      next_state.extSync2 = state.extSync1;
      next_state.extPrev  = state.extSync2;
      // One wait state: ready rises in the second access cycle
      next_state.ready    = access && !state.ready;
      // Answer stands only in the ready cycle, so idle reads see zero
      next_state.slvErr   = 1'b0;
      next_state.rdata    = '0;
      if (access && !state.ready) begin
         next_state.slvErr = !(isCtrl || isCnt);
         if (isCtrl)
            next_state.rdata = {24'h000000, state.ctrl[idx] & CTRL_WR_MASK};
         else if (isCnt)
            next_state.rdata = {16'h0000, cnt[idx]};
      end
      // Write lands at the edge where ready is sampled high
      if (access && state.ready && pwrite && isCtrl)
         next_state.ctrl[idx] = pwdata[CTRL_W-1:0] & CTRL_WR_MASK;
      // Standby holds every control register at its initial value
      if (standby) begin
         for (int i = 0; i < NUM_CH; i++)
            next_state.ctrl[i] = CTRL_RESET;
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state.presc    <= PRESC_RESET;
         state.extSync1 <= '0;
         state.extSync2 <= '0;
         state.extPrev  <= '0;
         state.ctrl     <= '{default: CTRL_RESET};
         state.ready    <= 1'b0;
         state.rdata    <= '0;
         state.slvErr   <= 1'b0;
      end
      else
         state <= next_state;
   end

   assign prdata  = state.rdata;
   assign pready  = state.ready;
   assign pslverr = state.slvErr;
endmodule

// ==== dv/tcc_timer_unit_properties.sv ====
module tcc_timer_unit_checker (
   // Clock and reset
   input logic                                 sys_clk,
   input logic                                 reset_n,
   // APB
   input logic                                 psel,
   input logic                                 penable,
   input logic                                 pwrite,
   input logic [tcc_pkg::ADDR_W-1:0]           paddr,
   input logic [tcc_pkg::DATA_W-1:0]           pwdata,
   input logic [tcc_pkg::DATA_W-1:0]           prdata,
   input logic                                 pready,
   input logic                                 pslverr,
   // Events and counters
   input logic                                 standby,
   input logic [tcc_pkg::NUM_CH-1:0]           compareMatchA,
   input logic [tcc_pkg::NUM_CH-1:0]           captureA,
   input logic [tcc_pkg::NUM_CH-1:0]           regAIsCapture,
   input logic [tcc_pkg::NUM_CH-1:0]           compareMatchB,
   input logic [tcc_pkg::NUM_CH-1:0]           captureB,
   input logic [tcc_pkg::NUM_CH-1:0]           regBIsCapture,
   input logic [tcc_pkg::NUM_CH*tcc_pkg::CNT_W-1:0] channelCounter
);
   timeunit 1ns;
   timeprecision 1ps;
   import tcc_pkg::*;
   logic [CTRL_W-1:0] ctl0;
   logic [1:0]        upCnt;
   logic              evA, evB, badAddr;
   assign evA = regAIsCapture[0] ? captureA[0] : compareMatchA[0];
   assign evB = regBIsCapture[0] ? captureB[0] : compareMatchB[0];
   assign badAddr = paddr[1:0] != 2'h0 || paddr > 8'h30 || (paddr > 8'h10 && paddr < 8'h20);
   // Shadow of channel 0 control; the counter checks need its mode
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl0 <= CTRL_RESET;
         upCnt <= 2'h0;
      end else begin
         if (standby)
            ctl0 <= CTRL_RESET;
         else if (psel && penable && pready && pwrite && paddr == CTRL_BASE)
            ctl0 <= pwdata[7:0] & CTRL_WR_MASK;
         // Internal reset copy lags by two edges, counting starts after
         if (upCnt != 2'h3)
            upCnt <= upCnt + 2'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence apbSetup;
      psel && !penable;
   endsequence
   sequence waitThenReady;
      !pready ##1 pready;
   endsequence
   chk_one_wait_state: assert property (apbSetup |=> waitThenReady)
      else $error("pready not after one wait state");
   chk_ready_single: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready outside access or too long");
   chk_err_decode: assert property (pready |-> pslverr == badAddr)
      else $error("pslverr does not match address decode");
   chk_rsv_bit_zero: assert property (pready && !pwrite && paddr < 8'h20 |-> prdata[31:7] == 25'h0)
      else $error("control read shows bits above 6");
   chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata nonzero outside answer");
   chk_clear_by_a: assert property (ctl0[6:5] == CLR_GRA && evA |=> channelCounter[15:0] == 16'h0)
      else $error("register A event did not clear counter");
   chk_clear_by_b: assert property (ctl0[6:5] == CLR_GRB && evB |=> channelCounter[15:0] == 16'h0)
      else $error("register B event did not clear counter");
   chk_count_free: assert property (upCnt == 2'h3 && ctl0 == 8'h00 |=>
      channelCounter[15:0] == $past(channelCounter[15:0]) + 16'h1)
      else $error("counter did not step with clear none");
endmodule
bind tcc_timer_unit tcc_timer_unit_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .standby(standby), .compareMatchA(compareMatchA), .captureA(captureA),
   .regAIsCapture(regAIsCapture), .compareMatchB(compareMatchB), .captureB(captureB),
   .regBIsCapture(regBIsCapture), .channelCounter(channelCounter));

// ==== dv/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tcc_pkg::*;
   logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, lastErr, standby = 1'b0;
   logic        phaseMode = 1'b0, phaseUp = 1'b0, phaseDown = 1'b0;
   logic [3:0]  extClockPin = 4'h0;
   logic [4:0]  cmA = 5'h0, capA = 5'h0, aCap = 5'h0, cmB = 5'h0, capB = 5'h0, bCap = 5'h0, syncMember = 5'h0;
   logic [79:0] channelCounter;
   int          error_cnt = 0, cmp_count = 0, cycles = 0;
   tcc_timer_unit u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby(standby), .extClockPin(extClockPin), .compareMatchA(cmA), .captureA(capA),
      .regAIsCapture(aCap), .compareMatchB(cmB), .captureB(capB), .regBIsCapture(bCap),
      .syncMember(syncMember), .phaseMode(phaseMode), .phaseUp(phaseUp), .phaseDown(phaseDown),
      .channelCounter(channelCounter));
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Only pready or the bench timeout ends a wait for the answer
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic t_regs();
      for (int c = 0; c < NUM_CH; c++) begin
         apb(1'b0, 8'(4 * c), 32'h0);
         chk(rdata, 32'h0);
         apb(1'b1, 8'(4 * c), 32'hff);
         apb(1'b0, 8'(4 * c), 32'h0);
         chk(rdata, 32'h7f);
      end
      apb(1'b1, 8'h04, 32'h80);
      apb(1'b0, 8'h04, 32'h0);
      chk(rdata, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, lastErr}, 32'h1);
      apb(1'b1, 8'h0c, 32'h55);
      standby <= 1'b1;
      repeat (2) @(posedge sys_clk);
      standby <= 1'b0;
      apb(1'b0, 8'h0c, 32'h0);
      chk(rdata, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_clear();
      // ctl[14:7], events {capB,cmB,capA,cmA}[6:3], capture mode {B,A}[2:1], clears[0]
      logic [14:0] tbl [7] = '{15'h0028, 15'h1009, 15'h1010, 15'h1013, 15'h2021, 15'h2008, 15'h2045};
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 8'h00, {24'h0, tbl[i][14:7]});
         {bCap[0], aCap[0]} <= tbl[i][2:1];
         repeat (4) @(posedge sys_clk);
         {capB[0], cmB[0], capA[0], cmA[0]} <= tbl[i][6:3];
         @(posedge sys_clk);
         {capB[0], cmB[0], capA[0], cmA[0]} <= 4'h0;
         @(posedge sys_clk);
         chk({31'h0, channelCounter[15:0] == 16'h0}, {31'h0, tbl[i][0]});
      end
      apb(1'b1, 8'h0c, 32'h20);
      apb(1'b1, 8'h10, 32'h60);
      syncMember <= 5'h18;
      repeat (3) @(posedge sys_clk);
      cmA[3] <= 1'b1;
      @(posedge sys_clk);
      cmA[3] <= 1'b0;
      @(posedge sys_clk);
      chk({16'h0, channelCounter[79:64]}, 32'h0);
      chk({31'h0, channelCounter[31:16] == 16'h0}, 32'h0);
      $display("test clear done");
   endtask
   task automatic t_count();
      logic [15:0] base;
      // Free-running divider: any 16-cycle window holds exactly 16 >> p ticks
      for (int p = 1; p < 4; p++) begin
         apb(1'b1, 8'h00, 32'(p));
         base = channelCounter[15:0];
         repeat (16) @(posedge sys_clk);
         chk({16'h0, channelCounter[15:0] - base}, 32'(16 >> p));
      end
      for (int p = 4; p < 8; p++)
         for (int e = 0; e < 3; e++) begin
            apb(1'b1, 8'h00, 32'(e * 8 + p));
            repeat (8) @(posedge sys_clk);
            base = channelCounter[15:0];
            repeat (8) begin
               extClockPin[p - 4] <= ~extClockPin[p - 4];
               repeat (6) @(posedge sys_clk);
            end
            repeat (8) @(posedge sys_clk);
            chk({16'h0, channelCounter[15:0] - base}, (e == 2) ? 32'h8 : 32'h4);
         end
      // Prescaler every cycle: only the phase pulses may move channel 2
      apb(1'b1, 8'h08, 32'h0);
      phaseMode <= 1'b1;
      @(posedge sys_clk);
      base = channelCounter[47:32];
      repeat (3) begin
         phaseUp <= 1'b1;
         @(posedge sys_clk);
         phaseUp <= 1'b0;
         @(posedge sys_clk);
      end
      chk({16'h0, channelCounter[47:32] - base}, 32'h3);
      $display("test count done");
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_regs();
      t_clear();
      t_count();
      close_out();
   end
endmodule
